//--- verilog/crc16_byte_engine.sv
// Top of the 16-bit crc engine with sfr registers and flash auto mode
`timescale 1ns/1ps
// How it works
// RL1 - Crc16 with polynomial 0x1021, no reflection
// RL2 - Byte XORed into upper result half first
// RL3 - Eight shift steps, conditional polynomial XOR
// RL4 - Each byte input write updates result
// RL5 - Initialise bit loads whole result
// RL6 - Select bit chooses 0x0000 or 0xFFFF
// RL7 - Pointer picks low or high byte
// RL8 - Pointer toggles on each window access
// RL9 - Window write overwrites, read returns byte
// RL10 - Result holds unless preset, written, updated
// RL11 - Bit reverse register reads mirrored byte
// RL12 - Auto mode runs over 256-byte blocks
// RL13 - Control write with enable starts auto
// RL14 - Cpu stalled until auto run ends
// RL15 - Software follows auto run sequence
// RL16 - Software uses safe instructions after start
// RL17 - Software writes reserved bits reset value
// RL18 - Auto range from start*256 to end-1
// RL19 - Window invalid one cycle after preset
// RL20 - Enable bit7, start 5:0, count 4:0
// RL21 - Flash bytes ascending through same update
module crc16_byte_engine
#(
   parameter int START_W = checksum_unit_pkg::START_W,
   parameter int COUNT_W = checksum_unit_pkg::COUNT_W
)
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // Special function register bus
   input wire checksum_unit_pkg::sfr_req_t sfr_in,
   output logic [7:0] sfr_rdata_out,
   // Flash read port for automatic mode
   output logic flash_rd_out,
   output logic [START_W+7:0] flash_addr_out,
   input wire logic [7:0] flash_data_in,
   // Cpu stall
   output logic cpu_stall_out
);
   localparam int FAW = START_W + 8;

   logic [15:0] crc_q, crc_d, step_out;
   logic [7:0] step_byte;
   logic ptr_q, ptr_d, val_q, val_d;
   logic [7:0] flip_q, flip_d;
   logic auto_en_q, auto_en_d;
   logic [START_W-1:0] start_q, start_d;
   logic [COUNT_W-1:0] count_q, count_d;
   checksum_unit_pkg::auto_state_t st_q, st_d;
   logic [FAW-1:0] addr_q, addr_d, last_q, last_d;
   logic [7:0] rdata_q, rdata_d;

   // Address decode helper
   function automatic logic hit(input checksum_unit_pkg::sfr_req_t r,
                                input logic [7:0] a);
      hit = (r.addr == a);
   endfunction

   // Mirror bit order of a byte
   function automatic logic [7:0] mirror(input logic [7:0] b);
      for (int i = 0; i < 8; i++)
         mirror[i] = b[7-i];
   endfunction

   // Shared byte update datapath
   assign step_byte = (st_q == checksum_unit_pkg::ST_FOLD) ? flash_data_in
                      : sfr_in.wdata; // RL21
   crc16_byte_step u_step
   (
      .crc_in(crc_q),
      .byte_in(step_byte),
      .crc_out(step_out)
   );

   // Next-state for registers, result and auto engine
   always_comb
   begin
      logic wr_ctl;
      wr_ctl = sfr_in.wr && hit(sfr_in, checksum_unit_pkg::ADDR_CRC_CONTROL);
      crc_d = crc_q; // RL10
      ptr_d = ptr_q;
      val_d = val_q;
      flip_d = flip_q;
      auto_en_d = auto_en_q;
      start_d = start_q;
      count_d = count_q;
      st_d = st_q;
      addr_d = addr_q;
      last_d = last_q;
      case (st_q)
         checksum_unit_pkg::ST_IDLE:
         begin
            if (sfr_in.wr)
            begin
               if (wr_ctl)
               begin
                  val_d = sfr_in.wdata[checksum_unit_pkg::CTL_VAL_BIT];
                  ptr_d = sfr_in.wdata[checksum_unit_pkg::CTL_PNT_BIT];
                  if (sfr_in.wdata[checksum_unit_pkg::CTL_INIT_BIT])
                     crc_d = sfr_in.wdata[checksum_unit_pkg::CTL_VAL_BIT]
                             ? checksum_unit_pkg::PRESET_ONE
                             : checksum_unit_pkg::PRESET_ZERO; // RL5 RL6 RL19
                  if (auto_en_q && (count_q != '0))
                  begin
                     addr_d = {start_q, checksum_unit_pkg::BYTE_ZERO}; // RL18
                     last_d = FAW'({start_q, checksum_unit_pkg::BYTE_ZERO}
                              + {count_q, checksum_unit_pkg::BYTE_ZERO}
                              - 1'b1); // RL18
                     st_d = checksum_unit_pkg::ST_FETCH; // RL13
                  end
               end
               if (hit(sfr_in, checksum_unit_pkg::ADDR_BYTE_INPUT))
                  crc_d = step_out; // RL4
               if (hit(sfr_in, checksum_unit_pkg::ADDR_RESULT_WINDOW))
               begin
                  if (ptr_q)
                     crc_d[15:8] = sfr_in.wdata; // RL7 RL9
                  else
                     crc_d[7:0] = sfr_in.wdata; // RL7 RL9
                  ptr_d = ~ptr_q; // RL8
               end
               if (hit(sfr_in, checksum_unit_pkg::ADDR_BIT_REVERSE))
                  flip_d = sfr_in.wdata;
               if (hit(sfr_in, checksum_unit_pkg::ADDR_AUTO_CONTROL))
               begin
                  auto_en_d = sfr_in.wdata[checksum_unit_pkg::AUTO_EN_BIT];
                  start_d = sfr_in.wdata[START_W-1:0]; // RL20
               end
               if (hit(sfr_in, checksum_unit_pkg::ADDR_BLOCK_COUNT))
                  count_d = sfr_in.wdata[COUNT_W-1:0]; // RL20
            end
            else if (sfr_in.rd &&
                     hit(sfr_in, checksum_unit_pkg::ADDR_RESULT_WINDOW))
               ptr_d = ~ptr_q; // RL8
         end
         checksum_unit_pkg::ST_FETCH:
            st_d = checksum_unit_pkg::ST_FOLD; // RL12
         checksum_unit_pkg::ST_FOLD:
         begin
            crc_d = step_out; // RL21
            if (addr_q == last_q)
               st_d = checksum_unit_pkg::ST_IDLE;
            else
            begin
               addr_d = FAW'(addr_q + 1'b1); // RL21
               st_d = checksum_unit_pkg::ST_FETCH;
            end
         end
         default:
            st_d = checksum_unit_pkg::ST_IDLE;
      endcase
   end

   // Read data mux, registered
   always_comb
   begin
      rdata_d = '0;
      case (sfr_in.addr)
         checksum_unit_pkg::ADDR_CRC_CONTROL:
            // Reserved bit 4 reads back its reset value of one
            rdata_d = checksum_unit_pkg::CTL_RESET
                      | {5'b0_0000, val_q, 1'b0, ptr_q};
         checksum_unit_pkg::ADDR_BYTE_INPUT:
            rdata_d = '0;
         checksum_unit_pkg::ADDR_RESULT_WINDOW:
            rdata_d = ptr_q ? crc_q[15:8] : crc_q[7:0]; // RL7 RL9
         checksum_unit_pkg::ADDR_BIT_REVERSE:
            rdata_d = mirror(flip_q); // RL11
         checksum_unit_pkg::ADDR_AUTO_CONTROL:
            rdata_d = {auto_en_q, 1'b0, 6'(start_q)};
         checksum_unit_pkg::ADDR_BLOCK_COUNT:
            rdata_d = {(st_q == checksum_unit_pkg::ST_IDLE), 2'b00,
                       5'(count_q)};
         default:
            rdata_d = '0;
      endcase
      if (!sfr_in.rd)
         rdata_d = rdata_q;
   end

   // State registers
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         crc_q <= checksum_unit_pkg::PRESET_ZERO;
         ptr_q <= 1'b0;
         val_q <= 1'b0;
         flip_q <= '0;
         auto_en_q <= 1'b0;
         start_q <= '0;
         count_q <= '0;
         st_q <= checksum_unit_pkg::ST_IDLE;
         addr_q <= '0;
         last_q <= '0;
         rdata_q <= '0;
      end
      else
      begin
         crc_q <= crc_d;
         ptr_q <= ptr_d;
         val_q <= val_d;
         flip_q <= flip_d;
         auto_en_q <= auto_en_d;
         start_q <= start_d;
         count_q <= count_d;
         st_q <= st_d;
         addr_q <= addr_d;
         last_q <= last_d;
         rdata_q <= rdata_d;
      end
   end

   // Outputs
   assign sfr_rdata_out = rdata_q;
   assign flash_rd_out = (st_q == checksum_unit_pkg::ST_FETCH);
   assign flash_addr_out = addr_q;
   assign cpu_stall_out = (st_q != checksum_unit_pkg::ST_IDLE); // RL14

   // Assertions
   property p_preset;
      @(posedge ref_clk_in) disable iff (rst_in)
      (st_q == checksum_unit_pkg::ST_IDLE && sfr_in.wr &&
       sfr_in.addr == checksum_unit_pkg::ADDR_CRC_CONTROL &&
       sfr_in.wdata[checksum_unit_pkg::CTL_INIT_BIT]) |=>
      crc_q == ($past(sfr_in.wdata[checksum_unit_pkg::CTL_VAL_BIT])
                ? checksum_unit_pkg::PRESET_ONE
                : checksum_unit_pkg::PRESET_ZERO);
   endproperty
   a_preset: assert property (p_preset) else $error("preset wrong"); // RL5
   property p_ptr;
      @(posedge ref_clk_in) disable iff (rst_in)
      (st_q == checksum_unit_pkg::ST_IDLE && (sfr_in.rd || sfr_in.wr) &&
       sfr_in.addr == checksum_unit_pkg::ADDR_RESULT_WINDOW)
      |=> ptr_q != $past(ptr_q);
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer no toggle"); // RL8
   property p_flip;
      @(posedge ref_clk_in) disable iff (rst_in)
      sfr_in.rd && sfr_in.addr == checksum_unit_pkg::ADDR_BIT_REVERSE
      |=> sfr_rdata_out == 8'({<<{$past(flip_q)}});
   endproperty
   a_flip: assert property (p_flip) else $error("flip wrong"); // RL11
   property p_hold;
      @(posedge ref_clk_in) disable iff (rst_in)
      (st_q == checksum_unit_pkg::ST_IDLE && !sfr_in.wr) |=> $stable(crc_q);
   endproperty
   a_hold: assert property (p_hold) else $error("result changed"); // RL10
   property p_stall;
      @(posedge ref_clk_in) disable iff (rst_in)
      $rose(cpu_stall_out) |-> addr_q[7:0] == 8'h00 && flash_rd_out;
   endproperty
   a_stall: assert property (p_stall) else $error("bad run start"); // RL18
   property p_fold;
      @(posedge ref_clk_in) disable iff (rst_in)
      flash_rd_out |=> st_q == checksum_unit_pkg::ST_FOLD ##1
      (flash_rd_out || !cpu_stall_out);
   endproperty
   a_fold: assert property (p_fold) else $error("fetch order"); // RL21
   property p_ascend;
      @(posedge ref_clk_in) disable iff (rst_in)
      flash_rd_out ##2 flash_rd_out |-> flash_addr_out ==
      FAW'($past(flash_addr_out, 2) + 1'b1);
   endproperty
   a_ascend: assert property (p_ascend) else $error("addr skip"); // RL12
   property p_input;
      @(posedge ref_clk_in) disable iff (rst_in)
      (st_q == checksum_unit_pkg::ST_IDLE && sfr_in.wr &&
       sfr_in.addr == checksum_unit_pkg::ADDR_BYTE_INPUT) |=>
      crc_q == $past(step_out);
   endproperty
   a_input: assert property (p_input) else $error("no update"); // RL4
   c_run: cover property (@(posedge ref_clk_in) $fell(cpu_stall_out));
   c_in: cover property (@(posedge ref_clk_in)
      sfr_in.wr && sfr_in.addr == checksum_unit_pkg::ADDR_BYTE_INPUT);
   c_win: cover property (@(posedge ref_clk_in)
      sfr_in.rd && sfr_in.addr == checksum_unit_pkg::ADDR_RESULT_WINDOW);
endmodule

//--- verilog/checksum_unit_pkg.sv
// Package with register map, field layout and types for the checksum unit
package checksum_unit_pkg;
   // Register addresses on the special function register bus
   localparam logic [7:0] ADDR_CRC_CONTROL = 8'hCE;
   localparam logic [7:0] ADDR_BIT_REVERSE = 8'hCF;
   localparam logic [7:0] ADDR_AUTO_CONTROL = 8'hD2;
   localparam logic [7:0] ADDR_BLOCK_COUNT = 8'hD3;
   localparam logic [7:0] ADDR_BYTE_INPUT = 8'hDD;
   localparam logic [7:0] ADDR_RESULT_WINDOW = 8'hDE;
   // Control register fields
   localparam int CTL_INIT_BIT = 3;
   localparam int CTL_VAL_BIT = 2;
   localparam int CTL_PNT_BIT = 0;
   localparam logic [7:0] CTL_RESET = 8'h10;
   localparam logic [7:0] CTL_RW_MASK = 8'h05;
   // Automatic control fields
   localparam int AUTO_EN_BIT = 7;
   localparam int START_W = 6;
   localparam int COUNT_W = 5;
   localparam int DONE_BIT = 7;
   // Crc constants
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] PRESET_ZERO = 16'h0000;
   localparam logic [15:0] PRESET_ONE = 16'hFFFF;
   localparam int BLOCK_ADDR_W = 8;
   localparam int FLASH_ADDR_W = START_W + BLOCK_ADDR_W;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // Special function register access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   // Automatic engine states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_FOLD = 2'b10
   } auto_state_t;
endpackage

//--- verilog/crc16_byte_step.sv
// Combinational one-byte update of a 16-bit crc, msb first
`timescale 1ns/1ps
module crc16_byte_step
(
   // Current value and byte
   input wire logic [15:0] crc_in,
   input wire logic [7:0] byte_in,
   // Updated value
   output logic [15:0] crc_out
);
   // Fold byte into upper half, then eight shift steps
   always_comb
   begin
      logic [15:0] acc;
      acc = crc_in ^ {byte_in, checksum_unit_pkg::BYTE_ZERO}; // RL2
      for (int i = 0; i < 8; i++)
      begin
         if (acc[15])
            acc = {acc[14:0], 1'b0} ^ checksum_unit_pkg::CRC_POLY; // RL3
         else
            acc = {acc[14:0], 1'b0}; // RL3
      end
      crc_out = acc; // RL1
   end
endmodule

//--- dv/flash_model.sv
// Flash memory model answering the automatic fetch port
`timescale 1ns/1ps
module flash_model
(
   // Clock
   input wire logic ref_clk_in,
   // Fetch request
   input wire logic flash_rd_in,
   input wire logic [13:0] flash_addr_in,
   // Fetched byte
   output logic [7:0] flash_data_out
);
   initial flash_data_out = 8'h5A;
   // Byte valid the cycle after a fetch, toggling junk otherwise
   always @(posedge ref_clk_in)
   begin
      if (flash_rd_in)
         flash_data_out <= flash_addr_in[7:0] ^ {flash_addr_in[13:8], 2'h1};
      else
         flash_data_out <= ~flash_data_out;
   end
endmodule

//--- dv/tb.sv
// Self-checking testbench of the crc engine with flash model
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
mismatches++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   checksum_unit_pkg::sfr_req_t req = '0;
   logic [7:0] sfr_rdata_out, flash_data, b;
   logic flash_rd_out, cpu_stall_out;
   logic [13:0] flash_addr_out, exp_addr;
   logic [15:0] exp, w;
   logic [5:0] st;
   int mismatches = 0, total_checks = 0, fetches, i, j, n;
   integer seed = 32'h9dad0bc9;

   // Design and far-side flash
   crc16_byte_engine i_crc16_byte_engine (.ref_clk_in, .rst_in,
      .sfr_in(req), .sfr_rdata_out, .flash_rd_out, .flash_addr_out,
      .flash_data_in(flash_data), .cpu_stall_out);
   flash_model i_flash_model (.ref_clk_in, .flash_rd_in(flash_rd_out),
      .flash_addr_in(flash_addr_out), .flash_data_out(flash_data));

   always #5 ref_clk_in = ~ref_clk_in;

   // Reference byte update, msb first
   function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
      c = c ^ {d, 8'h00};
      for (int k = 0; k < 8; k++)
         c = c[15] ? ((c << 1) ^ checksum_unit_pkg::CRC_POLY) : (c << 1);
      return c;
   endfunction

   // Mirrored byte
   function automatic logic [7:0] rev(logic [7:0] d);
      for (int k = 0; k < 8; k++)
         rev[k] = d[7 - k];
   endfunction

   // Flash content pattern
   function automatic logic [7:0] fbyte(logic [13:0] a);
      return a[7:0] ^ {a[13:8], 2'h1};
   endfunction

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Register write, held until the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk_in);
      req <= '0;
   endtask

   // Register read compared with expectation
   task automatic rd(input string nm, input logic [7:0] a,
      input logic [7:0] e);
      @(posedge ref_clk_in);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk_in);
      req <= '0;
      #1;
      `CHK(nm, e, sfr_rdata_out)
   endtask

   // Result read low then high byte
   task automatic res(input logic [15:0] e);
      rd("res_lo", checksum_unit_pkg::ADDR_RESULT_WINDOW, e[7:0]);
      rd("res_hi", checksum_unit_pkg::ADDR_RESULT_WINDOW, e[15:8]);
   endtask

   // Preset, then one spare cycle before any window read
   task automatic preset(input logic v);
      wr(checksum_unit_pkg::ADDR_CRC_CONTROL, {4'h1, 1'b1, v, 2'h0});
      exp = v ? 16'hFFFF : 16'h0000;
      @(posedge ref_clk_in);
   endtask

   // Bounded wait for the end of an automatic run
   task automatic wait_idle();
      int k;
      for (k = 0; k < 2000; k++)
      begin
         @(negedge ref_clk_in);
         if (cpu_stall_out !== 1'b1)
            break;
      end
      if (k == 2000)
      begin
         mismatches++;
         print_verdict();
      end
   endtask

   // Fetch monitor: ascending addresses under stall
   always @(posedge ref_clk_in)
   begin
      if (!rst_in && flash_rd_out === 1'b1)
      begin
         `CHK("flash_addr", exp_addr, flash_addr_out)
         `CHK("stall", 1'b1, cpu_stall_out)
         exp_addr++;
         fetches++;
      end
   end

   // Main sequence
   initial
   begin
      repeat (8) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      rd("done_rst", checksum_unit_pkg::ADDR_BLOCK_COUNT, 8'h80);
      rd("ctl_rst", checksum_unit_pkg::ADDR_CRC_CONTROL,
         checksum_unit_pkg::CTL_RESET);
      res(16'h0000);
      for (i = 0; i < 2; i++)
      begin
         preset(i[0]);
         res(exp);
      end
      // Random byte streams of one to eight bytes, each after a preset
      for (i = 0; i < 6; i++)
      begin
         preset(i[0]);
         n = 1 + ($random(seed) & 7);
         for (j = 0; j < n; j++)
         begin
            b = 8'($random(seed));
            wr(checksum_unit_pkg::ADDR_BYTE_INPUT, b);
            exp = crc_step(exp, b);
         end
         repeat (3) @(posedge ref_clk_in);
         res(exp);
      end
      // Overwrite through the window, then fold one byte
      w = 16'($random(seed));
      wr(checksum_unit_pkg::ADDR_RESULT_WINDOW, w[7:0]);
      wr(checksum_unit_pkg::ADDR_RESULT_WINDOW, w[15:8]);
      res(w);
      wr(checksum_unit_pkg::ADDR_BYTE_INPUT, 8'hA5);
      exp = crc_step(w, 8'hA5);
      wr(checksum_unit_pkg::ADDR_CRC_CONTROL, 8'h11);
      rd("ctl", checksum_unit_pkg::ADDR_CRC_CONTROL, 8'h11);
      rd("ptr_hi", checksum_unit_pkg::ADDR_RESULT_WINDOW, exp[15:8]);
      rd("ptr_lo", checksum_unit_pkg::ADDR_RESULT_WINDOW, exp[7:0]);
      // Bit reverse
      for (i = 0; i < 5; i++)
      begin
         b = (i == 0) ? 8'hC0 : 8'($random(seed));
         wr(checksum_unit_pkg::ADDR_BIT_REVERSE, b);
         rd("flip", checksum_unit_pkg::ADDR_BIT_REVERSE, rev(b));
      end
      wr(8'h00, 8'hFF);
      rd("unmapped", 8'h00, 8'h00);
      // Automatic runs of one and two blocks
      for (i = 0; i < 2; i++)
      begin
         st = 6'($random(seed) & 31);
         preset(1'b1);
         exp_addr = {st, 8'h00};
         for (j = 0; j < (i + 1) * 256; j++)
            exp = crc_step(exp, fbyte(exp_addr + j[13:0]));
         fetches = 0;
         wr(checksum_unit_pkg::ADDR_AUTO_CONTROL, {2'h2, st});
         wr(checksum_unit_pkg::ADDR_BLOCK_COUNT, 8'(i + 1));
         wr(checksum_unit_pkg::ADDR_CRC_CONTROL, 8'h10);
         wr(checksum_unit_pkg::ADDR_BIT_REVERSE, 8'h3C);
         wait_idle();
         `CHK("fetches", (i + 1) * 256, fetches)
         wr(checksum_unit_pkg::ADDR_AUTO_CONTROL, {2'h0, st});
         rd("done", checksum_unit_pkg::ADDR_BLOCK_COUNT, 8'(8'h80 + i + 1));
         res(exp);
         wr(checksum_unit_pkg::ADDR_CRC_CONTROL, 8'h10);
         repeat (3) @(negedge ref_clk_in);
         `CHK("no_run", 1'b0, cpu_stall_out)
      end
      print_verdict();
   end
endmodule
